//--- include/vpi_pkg.sv
// Shared constants, field positions and types of the vector sequencer
package vpi_pkg;
   // ====================
   // Widths
   localparam int DW = 64;
   localparam int LW = 16;
   localparam int AW = 8;
   // ====================
   // Register byte offsets
   localparam logic [AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [AW-1:0] OFF_RLEN = 8'h04;
   localparam logic [AW-1:0] OFF_ALEN = 8'h08;
   localparam logic [AW-1:0] OFF_BLEN = 8'h0C;
   localparam logic [AW-1:0] OFF_KLO = 8'h10;
   localparam logic [AW-1:0] OFF_KHI = 8'h14;
   localparam logic [AW-1:0] OFF_STATUS = 8'h18;
   localparam logic [AW-1:0] OFF_MASK = 8'h1C;
   localparam logic [AW-1:0] OFF_STATE = 8'h20;
   // ====================
   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_OP_BIT = 1;
   localparam int CTRL_CTLV_BIT = 2;
   localparam int CTRL_BCAST_BIT = 3;
   localparam int ST_W = 4;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_OVF_BIT = 1;
   localparam int ST_ZERO_BIT = 2;
   localparam int ST_INDEF_BIT = 3;
   localparam int STATE_ELEM_LSB = 16;
   // ====================
   // Reset values
   localparam logic [LW-1:0] LEN_RST = 16'h0000;
   localparam logic [DW-1:0] K_RST = 64'h0000_0000_0000_0000;
   localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;
   // Integer one (64'h1) fed for missing arguments (plain default)
   localparam logic [DW-1:0] FP_ONE = 64'h0000_0000_0000_0001;
   // ====================
   // Types
   typedef enum logic {OP_POLY = 1'b0, OP_RAMP = 1'b1} op_t;
   typedef enum logic [1:0] {FN_ADD_UNNORM = 2'h1, FN_MUL_UPPER = 2'h2} pipe_fn_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_CTL = 3'h1,
      S_FETCH_A = 3'h3,
      S_FETCH_B = 3'h2,
      S_MUL = 3'h6,
      S_ADD = 3'h7,
      S_STORE = 3'h5
   } seq_state_t;
endpackage

//--- include/regs_if.sv
// Control and event carrier between the register file and the sequencer
`timescale 1ns/1ps
interface regs_if;
   import vpi_pkg::*;
   logic start;
   op_t op;
   logic ctl_en;
   logic bcast;
   logic [LW-1:0] rlen;
   logic [LW-1:0] alen;
   logic [LW-1:0] blen;
   logic [DW-1:0] kconst;
   logic busy;
   logic [LW-1:0] elem;
   logic ev_done;
   logic ev_ovf;
   logic ev_zero;
   logic ev_indef;
   modport regs (output start, op, ctl_en, bcast, rlen, alen, blen, kconst,
                 input busy, elem, ev_done, ev_ovf, ev_zero, ev_indef);
   modport seq (input start, op, ctl_en, bcast, rlen, alen, blen, kconst,
                output busy, elem, ev_done, ev_ovf, ev_zero, ev_indef);
endinterface

//--- hw/flag_defer.sv
// Data flag deferral across elements whose store is suppressed
`timescale 1ns/1ps
module flag_defer (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic commit_i,
   input wire logic perm_i,
   input wire logic ovf_i,
   input wire logic zero_i,
   input wire logic indef_i,
   output logic ovf_o,
   output logic zero_o,
   output logic indef_o
);
   typedef struct packed {
      logic [2:0] pend;
      logic [2:0] set;
   } defer_s_t;
   defer_s_t s_r, s_nxt;

   // ====================
   // Hold flags of unstored elements until a permitted store
   always_comb begin
      s_nxt = s_r;
      s_nxt.set = 3'h0;
      if (commit_i) begin
         if (perm_i) begin
            s_nxt.set = s_r.pend | {indef_i, zero_i, ovf_i}; // [RULE9] [RULE10]
            s_nxt.pend = 3'h0;
         end else begin
            s_nxt.pend = s_r.pend | {indef_i, zero_i, ovf_i}; // [RULE9] [RULE10]
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign {indef_o, zero_o, ovf_o} = s_r.set;
endmodule // flag_defer

//--- hw/vpi_regs.sv
// APB register file with sticky status and interrupt mask
`timescale 1ns/1ps
module vpi_regs
   import vpi_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   regs_if.regs rif
);
   typedef struct packed {
      logic start;
      logic op;
      logic ctl_en;
      logic bcast;
      logic [LW-1:0] rlen;
      logic [LW-1:0] alen;
      logic [LW-1:0] blen;
      logic [DW-1:0] kconst;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic [31:0] rdata;
      logic err;
      logic irq;
   } regs_s_t;
   regs_s_t s_r, s_nxt;
   logic wr;
   logic [ST_W-1:0] ev;

   // ====================
   // Decode: read data is fetched in setup so access can finish at once
   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      wr = psel_i && penable_i && pwrite_i;
      ev = {rif.ev_indef, rif.ev_zero, rif.ev_ovf, rif.ev_done};
      if (psel_i && !penable_i) begin
         s_nxt.err = 1'b0;
         unique case (paddr_i)
            OFF_CTRL: s_nxt.rdata = {28'h000_0000, s_r.bcast, s_r.ctl_en, s_r.op, 1'b0};
            OFF_RLEN: s_nxt.rdata = {16'h0000, s_r.rlen};
            OFF_ALEN: s_nxt.rdata = {16'h0000, s_r.alen};
            OFF_BLEN: s_nxt.rdata = {16'h0000, s_r.blen};
            OFF_KLO: s_nxt.rdata = s_r.kconst[31:0];
            OFF_KHI: s_nxt.rdata = s_r.kconst[63:32];
            OFF_STATUS: s_nxt.rdata = {28'h000_0000, s_r.status};
            OFF_MASK: s_nxt.rdata = {28'h000_0000, s_r.mask};
            OFF_STATE: s_nxt.rdata = {rif.elem, 15'h0000, rif.busy};
            default: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.err = 1'b1;
            end
         endcase
      end
      if (wr) begin
         unique case (paddr_i)
            OFF_CTRL: begin
               s_nxt.start = pwdata_i[CTRL_START_BIT] && !rif.busy; // Ignored while busy
               s_nxt.op = pwdata_i[CTRL_OP_BIT];
               s_nxt.ctl_en = pwdata_i[CTRL_CTLV_BIT];
               s_nxt.bcast = pwdata_i[CTRL_BCAST_BIT];
            end
            OFF_RLEN: s_nxt.rlen = pwdata_i[LW-1:0];
            OFF_ALEN: s_nxt.alen = pwdata_i[LW-1:0];
            OFF_BLEN: s_nxt.blen = pwdata_i[LW-1:0];
            OFF_KLO: s_nxt.kconst[31:0] = pwdata_i;
            OFF_KHI: s_nxt.kconst[63:32] = pwdata_i;
            OFF_STATUS: s_nxt.status = s_r.status & ~pwdata_i[ST_W-1:0];
            OFF_MASK: s_nxt.mask = pwdata_i[ST_W-1:0];
            default: ;
         endcase
      end
      // Set after clear so a same-cycle event wins
      s_nxt.status = s_nxt.status | ev;
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '{rlen: LEN_RST, alen: LEN_RST, blen: LEN_RST, kconst: K_RST,
                  status: STATUS_RST, mask: MASK_RST, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o = s_r.rdata;
   assign pready_o = 1'b1;
   assign pslverr_o = s_r.err;
   assign irq_o = s_r.irq;
   assign rif.start = s_r.start;
   assign rif.op = op_t'(s_r.op);
   assign rif.ctl_en = s_r.ctl_en;
   assign rif.bcast = s_r.bcast;
   assign rif.rlen = s_r.rlen;
   assign rif.alen = s_r.alen;
   assign rif.blen = s_r.blen;
   assign rif.kconst = s_r.kconst;
endmodule // vpi_regs

//--- hw/vector_poly_interval_seq.sv
// Sequencer for polynomial evaluation and interval ramp vector operations
//
// Summary of operation
// RULE1 - Polynomial raises only overflow, zero, indefinite
// RULE2 - Zero and indefinite come from final element
// RULE3 - Overflow in any step sets overflow
// RULE4 - First ramp element equals register constant
// RULE5 - Each later element adds constant to previous
// RULE6 - Ramp additions are unnormalized floating adds
// RULE7 - One element per control bit in field
// RULE8 - Suppressed element still computed and carried
// RULE9 - Suppressed indefinite flagged at next permitted store
// RULE10 - Suppressed overflow or zero deferred likewise
// RULE11 - Program zeroes unused designator and subfunction bits
// RULE12 - Ramp steers operands through add pipelines
// RULE13 - Empty constant vector makes polynomial a no-op
// RULE14 - Missing arguments supplied as normalized ones; the code feeds FP_ONE, an integer one (64'h1)
// RULE15 - Constant vector is never broadcast
// RULE16 - Upper multiply and unnormalized add for polynomial
// RULE17 - Horner scheme until constants are exhausted
// RULE18 - One constant undefined; two and three apply Horner
// RULE19 - Ramp ends after result field length elements
`timescale 1ns/1ps
module vector_poly_interval_seq
   import vpi_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   // Argument vector stream
   input wire logic arg_valid_i,
   input wire logic [DW-1:0] arg_data_i,
   output logic arg_ready_o,
   // Constant vector indexed read
   output logic cst_req_o,
   output logic [LW-1:0] cst_idx_o,
   input wire logic cst_valid_i,
   input wire logic [DW-1:0] cst_data_i,
   // Control vector bit stream
   input wire logic ctl_valid_i,
   input wire logic ctl_bit_i,
   output logic ctl_ready_o,
   // Arithmetic pipeline
   output logic pipe_req_o,
   output pipe_fn_t pipe_fn_o,
   output logic [DW-1:0] pipe_a_o,
   output logic [DW-1:0] pipe_b_o,
   input wire logic pipe_rsp_valid_i,
   input wire logic [DW-1:0] pipe_rsp_data_i,
   input wire logic pipe_rsp_ovf_i,
   input wire logic pipe_rsp_zero_i,
   input wire logic pipe_rsp_indef_i,
   // Result vector stream
   output logic res_valid_o,
   output logic [DW-1:0] res_data_o,
   output logic [LW-1:0] res_idx_o,
   input wire logic res_ready_i
);
   // ====================
   // Reset release through two flops
   logic [1:0] rst_sync_r;
   logic rst_b;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_r[1];

   // ====================
   // Register file
   regs_if rif ();

   vpi_regs u_regs (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .irq_o(irq_o),
      .rif(rif.regs)
   );

   // ====================
   // Sequencer state
   typedef struct packed {
      seq_state_t st;
      op_t op;
      logic ctl_en;
      logic bcast;
      logic perm;
      logic [LW-1:0] elem;
      logic [LW-1:0] k;
      logic [DW-1:0] acc;
      logic [DW-1:0] arg;
      logic req;
      logic creq;
      pipe_fn_t fn;
      logic [DW-1:0] pa;
      logic [DW-1:0] pb;
      logic fo;
      logic fz;
      logic fi;
      logic done;
   } seq_s_t;
   seq_s_t s_r, s_nxt;
   logic commit;
   logic fetch_arg;
   logic last_elem;

   // ====================
   // Sequencer next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.req = 1'b0;
      s_nxt.creq = 1'b0;
      s_nxt.done = 1'b0;
      commit = 1'b0;
      last_elem = (s_r.elem + 16'h0001) == rif.rlen;
      // Broadcast holds element zero; past the field a one is used
      fetch_arg = !(s_r.bcast && s_r.elem != 16'h0000) && (s_r.elem < rif.alen);
      unique case (s_r.st)
         S_IDLE: begin
            if (rif.start) begin
               s_nxt.op = rif.op;
               s_nxt.ctl_en = rif.ctl_en;
               s_nxt.bcast = rif.bcast;
               s_nxt.elem = 16'h0000;
               // Empty field, or polynomial with no constants: finish with nothing stored
               if (rif.rlen == 16'h0000 ||
                   (rif.op == OP_POLY && rif.blen == 16'h0000)) begin // [RULE13]
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.st = S_CTL;
               end
            end
         end
         S_CTL: begin
            s_nxt.fo = 1'b0;
            s_nxt.fz = 1'b0;
            s_nxt.fi = 1'b0;
            // Each control bit yields an element, stored or not
            if (!s_r.ctl_en || ctl_valid_i) begin // [RULE7]
               s_nxt.perm = !s_r.ctl_en || ctl_bit_i;
               if (s_r.op == OP_RAMP) begin
                  if (s_r.elem == 16'h0000) begin
                     s_nxt.acc = rif.kconst; // [RULE4]
                     s_nxt.st = S_STORE;
                  end else begin
                     // Running sum on the add pipeline
                     s_nxt.pa = s_r.acc; // [RULE5]
                     s_nxt.pb = rif.kconst;
                     s_nxt.fn = FN_ADD_UNNORM; // [RULE6] [RULE12]
                     s_nxt.req = 1'b1;
                     s_nxt.st = S_ADD;
                  end
               end else begin
                  s_nxt.st = S_FETCH_A;
               end
            end
         end
         S_FETCH_A: begin
            if (!fetch_arg || arg_valid_i) begin
               if (fetch_arg) begin
                  s_nxt.arg = arg_data_i;
               end else if (!(s_r.bcast && s_r.elem != 16'h0000)) begin
                  s_nxt.arg = FP_ONE; // [RULE14]
               end
               s_nxt.k = 16'h0000;
               s_nxt.creq = 1'b1;
               s_nxt.st = S_FETCH_B;
            end
         end
         S_FETCH_B: begin
            if (cst_valid_i) begin
               if (s_r.k == 16'h0000) begin
                  s_nxt.acc = cst_data_i;
                  s_nxt.k = 16'h0001;
                  if (rif.blen == 16'h0001) begin
                     // Single constant: result passes it through unevaluated
                     s_nxt.st = S_STORE; // [RULE18]
                  end else begin
                     s_nxt.pa = cst_data_i; // [RULE17]
                     s_nxt.pb = s_r.arg;
                     s_nxt.fn = FN_MUL_UPPER; // [RULE16]
                     s_nxt.req = 1'b1;
                     s_nxt.st = S_MUL;
                  end
               end else begin
                  s_nxt.pa = s_r.acc; // [RULE17]
                  s_nxt.pb = cst_data_i;
                  s_nxt.fn = FN_ADD_UNNORM; // [RULE16]
                  s_nxt.req = 1'b1;
                  s_nxt.st = S_ADD;
               end
            end
         end
         S_MUL: begin
            if (pipe_rsp_valid_i) begin
               s_nxt.acc = pipe_rsp_data_i;
               s_nxt.fo = s_r.fo | pipe_rsp_ovf_i; // [RULE3]
               s_nxt.creq = 1'b1;
               s_nxt.st = S_FETCH_B;
            end
         end
         S_ADD: begin
            if (pipe_rsp_valid_i) begin
               s_nxt.acc = pipe_rsp_data_i;
               s_nxt.fo = s_r.fo | pipe_rsp_ovf_i; // [RULE3]
               // Later steps overwrite, so only the final result counts
               s_nxt.fz = pipe_rsp_zero_i; // [RULE2]
               s_nxt.fi = pipe_rsp_indef_i; // [RULE2]
               if (s_r.op == OP_RAMP) begin
                  s_nxt.st = S_STORE;
               end else if ((s_r.k + 16'h0001) == rif.blen) begin
                  s_nxt.st = S_STORE; // [RULE17] [RULE18]
               end else begin
                  s_nxt.k = s_r.k + 16'h0001;
                  s_nxt.pa = pipe_rsp_data_i;
                  s_nxt.pb = s_r.arg;
                  s_nxt.fn = FN_MUL_UPPER; // [RULE16]
                  s_nxt.req = 1'b1;
                  s_nxt.st = S_MUL;
               end
            end
         end
         S_STORE: begin
            // Suppressed element skips the write but keeps its sum
            if (!s_r.perm || res_ready_i) begin // [RULE8]
               commit = 1'b1;
               s_nxt.elem = s_r.elem + 16'h0001;
               if (last_elem) begin
                  s_nxt.done = 1'b1; // [RULE19]
                  s_nxt.st = S_IDLE;
               end else begin
                  s_nxt.st = S_CTL;
               end
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{st: S_IDLE, op: OP_POLY, fn: FN_ADD_UNNORM, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ====================
   // Flag deferral; only overflow, zero and indefinite exist
   flag_defer u_defer (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b),
      .commit_i(commit),
      .perm_i(s_r.perm),
      .ovf_i(s_r.fo), // [RULE1]
      .zero_i(s_r.fz),
      .indef_i(s_r.fi),
      .ovf_o(rif.ev_ovf),
      .zero_o(rif.ev_zero),
      .indef_o(rif.ev_indef)
   );

   // ====================
   // Outputs
   assign rif.busy = s_r.st != S_IDLE;
   assign rif.elem = s_r.elem;
   assign rif.ev_done = s_r.done;
   assign ctl_ready_o = (s_r.st == S_CTL) && s_r.ctl_en;
   assign arg_ready_o = (s_r.st == S_FETCH_A) && fetch_arg;
   // Constant index follows the pass, never held as broadcast
   assign cst_req_o = s_r.creq; // [RULE15]
   assign cst_idx_o = s_r.k;
   assign pipe_req_o = s_r.req;
   assign pipe_fn_o = s_r.fn;
   assign pipe_a_o = s_r.pa;
   assign pipe_b_o = s_r.pb;
   assign res_valid_o = (s_r.st == S_STORE) && s_r.perm;
   assign res_data_o = s_r.acc;
   assign res_idx_o = s_r.elem;
endmodule // vector_poly_interval_seq

//--- testbench/vpi_seq_props.sv
// Port-level concurrent checks for the vector sequencer
`timescale 1ns/1ps
module vpi_seq_props
   import vpi_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic cst_req_o,
   input wire logic cst_valid_i,
   input wire logic pipe_req_o,
   input wire pipe_fn_t pipe_fn_o,
   input wire logic [DW-1:0] pipe_a_o,
   input wire logic [DW-1:0] pipe_b_o,
   input wire logic pipe_rsp_valid_i,
   input wire logic res_valid_o,
   input wire logic [DW-1:0] res_data_o,
   input wire logic [LW-1:0] res_idx_o,
   input wire logic res_ready_i
);
   // ====================
   // Sequences
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence res_stall;
      res_valid_o && !res_ready_i;
   endsequence
   sequence pipe_issue;
      pipe_req_o ##1 !pipe_req_o;
   endsequence
   // ====================
   // Assertions
   chk_pready_high: assert property (pready_o)
      else $error("pready low");
   chk_slverr_map: assert property (psel_i && penable_i |->
      pslverr_o == !(paddr_i[1:0] == 2'h0 && paddr_i <= OFF_STATE))
      else $error("slverr wrong");
   chk_cst_wait: assert property (cst_req_o |=> !cst_req_o until cst_valid_i)
      else $error("cst req early");
   chk_pipe_wait: assert property (pipe_issue |-> !pipe_req_o until pipe_rsp_valid_i)
      else $error("pipe req early");
   chk_fn_legal: assert property (
      pipe_req_o |-> pipe_fn_o inside {FN_ADD_UNNORM, FN_MUL_UPPER})
      else $error("bad function");
   chk_pipe_stable: assert property (!pipe_req_o |-> $stable(pipe_a_o) && $stable(pipe_b_o))
      else $error("operands moved");
   chk_res_hold: assert property (res_stall |=>
      res_valid_o && $stable(res_data_o) && $stable(res_idx_o))
      else $error("result dropped");
   chk_pipe_pulse: assert property (pipe_req_o |=> !pipe_req_o)
      else $error("pipe req long");
endmodule // vpi_seq_props

//--- testbench/vpi_far_model.sv
// Far-side model: operand streams, arithmetic pipeline, result sink
`timescale 1ns/1ps
module vpi_far_model
   import vpi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rewind_i,
   input wire logic [1:0] slow_i,
   input wire logic [DW-1:0] trig_i,
   input wire logic [2:0] fl_i,
   input wire logic [15:0] mask_i,
   output logic arg_valid_o,
   output logic [DW-1:0] arg_data_o,
   input wire logic cst_req_i,
   input wire logic [LW-1:0] cst_idx_i,
   output logic cst_valid_o,
   output logic [DW-1:0] cst_data_o,
   output logic ctl_valid_o,
   output logic ctl_bit_o,
   input wire logic ctl_ready_i,
   input wire logic pipe_req_i,
   input wire pipe_fn_t pipe_fn_i,
   input wire logic [DW-1:0] pipe_a_i,
   input wire logic [DW-1:0] pipe_b_i,
   output logic pipe_valid_o,
   output logic [DW-1:0] pipe_data_o,
   output logic [2:0] pipe_fl_o,
   output logic res_ready_o = 1'b0
);
   int cidx = 0;
   logic [DW-1:0] r;
   // Fixed argument keeps expected results simple
   assign arg_valid_o = 1'b1;
   assign arg_data_o = 64'h0000_0000_0000_0003;
   assign ctl_valid_o = 1'b1;
   assign ctl_bit_o = mask_i[cidx[3:0]];
   // One control bit consumed per generated element
   always @(posedge clk_i)
      cidx <= rewind_i ? 0 : cidx + int'(ctl_ready_i);
   // Slow mode drops result ready on every other cycle
   always @(posedge clk_i)
      res_ready_o <= slow_i == 2'h0 || !res_ready_o;
   // Constant k is k plus one
   initial begin
      cst_valid_o = 1'b0;
      cst_data_o = '0;
      forever begin
         @(posedge clk_i);
         if (cst_req_i === 1'b1) begin
            r = 64'(cst_idx_i) + 64'h1;
            repeat (slow_i) @(posedge clk_i);
            cst_valid_o <= 1'b1;
            cst_data_o <= r;
            @(posedge clk_i);
            cst_valid_o <= 1'b0;
            cst_data_o <= ~r;
         end
      end
   end
   // Pipeline: flags only on a chosen result value
   initial begin
      pipe_valid_o = 1'b0;
      pipe_data_o = '0;
      pipe_fl_o = 3'h0;
      forever begin
         @(posedge clk_i);
         if (pipe_req_i === 1'b1) begin
            r = pipe_fn_i == FN_MUL_UPPER ? pipe_a_i * pipe_b_i : pipe_a_i + pipe_b_i;
            repeat (slow_i) @(posedge clk_i);
            pipe_valid_o <= 1'b1;
            pipe_data_o <= r;
            pipe_fl_o <= r == trig_i ? fl_i : 3'h0;
            @(posedge clk_i);
            pipe_valid_o <= 1'b0;
            pipe_data_o <= ~r;
            pipe_fl_o <= 3'h0;
         end
      end
   end
endmodule // vpi_far_model

//--- testbench/vector_poly_interval_seq_test.sv
// Self-checking bench of the polynomial and ramp sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module vector_poly_interval_seq_test
   import vpi_pkg::*;
;
   logic mclk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, rewind = 0, re;
   logic [AW-1:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, rq;
   logic [1:0] slow = 0;
   logic [2:0] fl = 0;
   logic [15:0] mask = 0;
   logic [DW-1:0] trig = 0;
   logic [DW-1:0] res [16];
   int nres, error_cnt = 0, check_count = 0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, irq_o, arg_valid_i, arg_ready_o, cst_req_o, cst_valid_i;
   wire ctl_valid_i, ctl_bit_i, ctl_ready_o, pipe_req_o, pipe_rsp_valid_i, res_valid_o;
   wire res_ready_i, pipe_rsp_ovf_i, pipe_rsp_zero_i, pipe_rsp_indef_i;
   wire [DW-1:0] arg_data_i, cst_data_i, pipe_a_o, pipe_b_o, pipe_rsp_data_i, res_data_o;
   wire [LW-1:0] cst_idx_o, res_idx_o;
   wire pipe_fn_t pipe_fn_o;
   vector_poly_interval_seq vector_poly_interval_seq_i (.*);
   vpi_far_model vpi_far_model_i (.clk_i(mclk_i), .rewind_i(rewind), .slow_i(slow),
      .trig_i(trig), .fl_i(fl), .mask_i(mask), .arg_valid_o(arg_valid_i),
      .arg_data_o(arg_data_i), .cst_req_i(cst_req_o), .cst_idx_i(cst_idx_o),
      .cst_valid_o(cst_valid_i), .cst_data_o(cst_data_i), .ctl_valid_o(ctl_valid_i),
      .ctl_bit_o(ctl_bit_i), .ctl_ready_i(ctl_ready_o), .pipe_req_i(pipe_req_o),
      .pipe_fn_i(pipe_fn_o), .pipe_a_i(pipe_a_o), .pipe_b_i(pipe_b_o),
      .pipe_valid_o(pipe_rsp_valid_i), .pipe_data_o(pipe_rsp_data_i),
      .pipe_fl_o({pipe_rsp_indef_i, pipe_rsp_zero_i, pipe_rsp_ovf_i}),
      .res_ready_o(res_ready_i));
   // ====================
   // Clock, result capture, bus tasks
   initial forever #5 mclk_i = ~mclk_i;
   // Capture accepted results by element number
   always @(posedge mclk_i)
      if (rewind) begin
         nres <= 0;
      end else if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
         res[res_idx_o[3:0]] <= res_data_o;
         nres <= nres + 1;
      end
   // Idle cycle after each transfer avoids double assignment at one edge
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rq = prdata_o;
      re = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge mclk_i);
   endtask
   task automatic run(input logic [31:0] c, r, al, bl, input logic [63:0] k);
      int n;
      apb(1, OFF_STATUS, 32'h0000_000f);
      rewind <= 1;
      @(posedge mclk_i);
      rewind <= 0;
      apb(1, OFF_RLEN, r);
      apb(1, OFF_ALEN, al);
      apb(1, OFF_BLEN, bl);
      apb(1, OFF_KLO, k[31:0]);
      apb(1, OFF_KHI, k[63:32]);
      apb(1, OFF_CTRL, c | 32'h0000_0001);
      n = 0;
      do begin
         apb(0, OFF_STATUS, 0);
         n++;
      end while (rq[ST_DONE_BIT] !== 1'b1 && n < 400);
      `CHK("done", 1'b1, rq[ST_DONE_BIT])
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ====================
   // Scenarios
   task automatic t_regs();
      apb(0, OFF_MASK, 0);
      `CHK("mask rst", 32'h0000_0000, rq)
      apb(0, 8'h24, 0);
      `CHK("unmapped err", 1'b1, re)
      `CHK("unmapped data", 32'h0000_0000, rq)
      $display("regs done");
   endtask
   task automatic t_ramp();
      slow <= 2;
      apb(1, OFF_MASK, 32'h0000_0001);
      run(32'h0000_0002, 4, 0, 0, 64'h2);
      `CHK("ramp count", 4, nres)
      `CHK("ramp first", 64'h2, res[0])
      for (int i = 1; i < 4; i++) `CHK("ramp elem", 64'(2 * i + 2), res[i])
      apb(0, OFF_STATE, 0);
      `CHK("state", 32'h0004_0000, rq)
      `CHK("irq set", 1'b1, irq_o)
      apb(1, OFF_STATUS, 32'h0000_0001);
      repeat (2) @(posedge mclk_i);
      `CHK("irq clear", 1'b0, irq_o)
      apb(1, OFF_MASK, 0);
      slow <= 0;
      $display("ramp done");
   endtask
   task automatic t_ramp_ctl();
      mask <= 16'h0005;
      trig <= 64'h2;
      fl <= 3'b101;
      run(32'h0000_0006, 4, 0, 0, 64'h1);
      `CHK("stored", 2, nres)
      `CHK("carried", 64'h3, res[2])
      `CHK("ctl bits", 4, vpi_far_model_i.cidx)
      `CHK("ovf late", 1'b1, rq[ST_OVF_BIT])
      `CHK("indef late", 1'b1, rq[ST_INDEF_BIT])
      `CHK("irq masked", 1'b0, irq_o)
      $display("ramp ctl done");
   endtask
   task automatic t_defer();
      mask <= 16'h0001;
      fl <= 3'b010;
      run(32'h0000_0006, 4, 0, 0, 64'h1);
      `CHK("zero held", 1'b0, rq[ST_ZERO_BIT])
      trig <= 0;
      run(32'h0000_0002, 2, 0, 0, 64'h1);
      `CHK("zero posted", 1'b1, rq[ST_ZERO_BIT])
      $display("defer done");
   endtask
   task automatic t_poly();
      mask <= 0;
      trig <= 64'h5;
      fl <= 3'b111;
      run(32'h0000_0000, 3, 2, 3, 64'h0);
      `CHK("poly count", 3, nres)
      `CHK("poly e0", 64'h12, res[0])
      `CHK("poly e1", 64'h12, res[1])
      `CHK("poly one", 64'h6, res[2])
      `CHK("poly ovf", 1'b1, rq[ST_OVF_BIT])
      `CHK("poly zero", 1'b0, rq[ST_ZERO_BIT])
      `CHK("poly indef", 1'b0, rq[ST_INDEF_BIT])
      fl <= 3'b100;
      run(32'h0000_0008, 1, 1, 2, 64'h0);
      `CHK("poly two", 64'h5, res[0])
      `CHK("final indef", 1'b1, rq[ST_INDEF_BIT])
      `CHK("no ovf", 1'b0, rq[ST_OVF_BIT])
      run(32'h0000_0000, 2, 2, 0, 64'h0);
      `CHK("noop", 0, nres)
      $display("poly done");
   endtask
   // ====================
   // Main sequence and watchdog
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1;
      repeat (3) @(posedge mclk_i);
      t_regs();
      t_ramp();
      t_ramp_ctl();
      t_defer();
      t_poly();
      summarize();
   end
   initial begin
      repeat (30000) @(posedge mclk_i);
      error_cnt++;
      summarize();
   end
endmodule // vector_poly_interval_seq_test
bind vector_poly_interval_seq vpi_seq_props vpi_seq_props_i (.*);
